// *** core/bit_sync2.sv ***
// Purpose: Two flip-flop synchroniser for a group of independent levels.
// Assumes: Each bit changes on its own; no word coherence is promised.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none

module bit_sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // Both stages take the reset constant so no false edge follows reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// *** core/eeprom_pkg.sv ***
// Purpose: Shared constants, types and helpers for the SPI EEPROM command and status block.
// Assumes: A 25 MHz system clock. The serial clock comes from the host.
// Notes:   Non-volatile bits are modelled as registers with fixed power-up values.
`default_nettype none

package eeprom_pkg;

    // Instruction codes. Bit 3 of the two memory codes may carry address bit 8.
    localparam logic [7:0] set_write_latch_cmd   = 8'h06;
    localparam logic [7:0] clear_write_latch_cmd = 8'h04;
    localparam logic [7:0] status_read_cmd       = 8'h05;
    localparam logic [7:0] status_write_cmd      = 8'h01;
    localparam logic [7:0] memory_read_cmd       = 8'h03;
    localparam logic [7:0] memory_write_cmd      = 8'h02;
    localparam logic [7:0] ADDR_HI_MASK          = 8'h08;

    typedef enum logic [2:0] {
        op_none         = 3'h0,
        op_set_latch    = 3'h1,
        op_clear_latch  = 3'h2,
        op_status_read  = 3'h3,
        op_status_write = 3'h4,
        op_mem_read     = 3'h5,
        op_mem_write    = 3'h6
    } op_kind_t;

    // Write cycle timer states, Gray coded along idle, run, done.
    typedef enum logic [1:0] {
        tmr_idle = 2'b00,
        tmr_run  = 2'b01,
        tmr_done = 2'b11
    } timer_state_t;

    // Status register bit positions.
    localparam int ST_BUSY    = 0;
    localparam int ST_LATCH   = 1;
    localparam int ST_BP_LO   = 2;
    localparam int ST_BP_HI   = 3;
    localparam int ST_LOCK    = 4;
    localparam int ST_PSEL    = 6;

    // Values after reset.
    localparam logic       PSEL_RESET = 1'b1;
    localparam logic       LOCK_RESET = 1'b1;
    localparam logic [1:0] BP_RESET   = 2'h0;
    localparam logic       LATCH_RESET = 1'b0;

    // Serial bit counts at the end of opcode, address and each byte.
    localparam logic [4:0] OPCODE_BITS   = 5'h08;
    localparam logic [4:0] ADDR_END_BITS = 5'h10;
    localparam logic [4:0] BYTE_END_BITS = 5'h18;
    localparam int         ID_PAGE_BYTES = 16;

    // Self-timed write, longest time rounded down to whole cycles.
    localparam int WC_TIME_MS    = 4;
    localparam int CLK_HZ        = 25_000_000;
    localparam int WC_CYCLES     = WC_TIME_MS * (CLK_HZ / 1000);
    localparam int EXEC_LATENCY  = 4;

    // Maps an instruction byte to its kind; unknown codes give op_none.
    function automatic op_kind_t decode_op(input logic [7:0] code, input logic hi_in_op);
        logic [7:0] masked;
        masked = hi_in_op ? (code & ~ADDR_HI_MASK) : code;
        if (code == set_write_latch_cmd) return op_set_latch;
        if (code == clear_write_latch_cmd) return op_clear_latch;
        if (code == status_read_cmd) return op_status_read;
        if (code == status_write_cmd) return op_status_write;
        if (masked == memory_read_cmd) return op_mem_read;
        if (masked == memory_write_cmd) return op_mem_write;
        return op_none;
    endfunction

    // True when the two top address bits fall in the range the protect bits cover.
    function automatic logic in_protected(input logic [1:0] top2, input logic [1:0] bp);
        case (bp)
            2'h0:    return 1'b0;
            2'h1:    return top2 == 2'h3;
            2'h2:    return top2[1];
            default: return 1'b1;
        endcase
    endfunction

endpackage

`default_nettype wire

// *** core/spi_eeprom_command_status.sv ***
// Purpose: Serial command decoder, status register and write protection of an SPI EEPROM.
// Assumes: Host uses SPI mode 0 or 3 and keeps the serial clock still while selected idle.
// Notes:   Only the last complete data byte of a write sequence is committed.
`timescale 1ns/10ps
`default_nettype none

module spi_eeprom_command_status #(
    parameter int ADDR_W    = 9,
    parameter int WC_CYCLES = eeprom_pkg::WC_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic spi_clk,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so_out,
    output logic      so_oe_n
);

    localparam int   MEM_BYTES = 1 << ADDR_W;
    localparam logic HI_IN_OP  = ADDR_W > 8;

    // Link side state.
    logic                 frame_rst;
    logic [4:0]           bit_cnt;
    logic [4:0]           next_cnt;
    logic                 past_addr;
    logic                 first_data;
    logic [7:0]           rx_sr;
    logic [7:0]           rx_byte;
    logic                 op_hi;
    logic [8:0]           full_addr;
    eeprom_pkg::op_kind_t op;
    eeprom_pkg::op_kind_t dec;
    eeprom_pkg::op_kind_t done_kind;
    logic                 frame_tgl;
    logic [ADDR_W-1:0]    cap_addr;
    logic [7:0]           cap_data;
    logic [7:0]           tx_sr;
    logic                 so_drive;
    logic [ADDR_W-1:0]    rd_ptr;
    logic [ADDR_W-1:0]    next_ptr;
    logic [7:0]           rd_byte;
    logic [7:0]           status_link;
    logic                 busy_link;

    // System side state.
    logic                 cs_s;
    logic                 tgl_s;
    logic                 wp_s;
    logic                 cs_prev;
    logic                 seen_tgl;
    logic                 frame_end;
    logic                 write_enable_latch_flag;
    logic [1:0]           bp;
    logic                 lock;
    logic                 psel;
    logic                 busy;
    logic                 wc_done;
    logic                 wr_ok;
    logic                 stat_wr_go;
    logic                 write_hit;
    logic                 write_go;
    logic                 access_go;
    logic                 both_clear;

    logic [7:0]           main_mem [MEM_BYTES];
    logic [7:0]           id_mem   [eeprom_pkg::ID_PAGE_BYTES];

    // Deselect ends the frame on its own signal; the link clock may stop at any time.
    assign frame_rst = cs_n | sys_rst;
    assign rx_byte   = {rx_sr[6:0], si};
    assign full_addr = {op_hi, rx_byte};
    assign dec       = eeprom_pkg::decode_op(rx_byte, HI_IN_OP);

    // Bits past the address wrap over one byte, so each later byte ends at sixteen.
    always_comb begin
        next_cnt = bit_cnt + 5'h01;
        if (next_cnt == eeprom_pkg::BYTE_END_BITS) begin
            next_cnt = eeprom_pkg::ADDR_END_BITS;
        end
    end

    // Input shifter and bit counter. Only the rising edge is used, whatever the idle level.
    always_ff @(posedge spi_clk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt   <= '0;
            past_addr <= 1'b0;
            rx_sr     <= '0;
            op_hi     <= 1'b0;
            op        <= eeprom_pkg::op_none;
        end else if (hold_n) begin
            bit_cnt <= next_cnt;
            rx_sr   <= rx_byte;
            if (next_cnt == eeprom_pkg::OPCODE_BITS) begin
                op    <= dec;
                op_hi <= rx_byte[3];
            end
            if (next_cnt == eeprom_pkg::ADDR_END_BITS) begin
                past_addr <= 1'b1;
            end
        end
    end

    // Result of the frame, held after the clock stops so the system side can take it
    // once the select rise has been synchronised. Not cleared by deselect for that reason.
    always_ff @(posedge spi_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_tgl  <= 1'b0;
            done_kind  <= eeprom_pkg::op_none;
            cap_addr   <= '0;
            cap_data   <= '0;
            first_data <= 1'b0;
        end else if (hold_n && !cs_n) begin
            if (bit_cnt == 5'h00) begin
                frame_tgl <= ~frame_tgl;
            end
            if (next_cnt == eeprom_pkg::OPCODE_BITS) begin
                if (dec == eeprom_pkg::op_set_latch || dec == eeprom_pkg::op_clear_latch) begin
                    done_kind <= dec;
                end else begin
                    done_kind <= eeprom_pkg::op_none;
                end
            end else if (next_cnt == eeprom_pkg::ADDR_END_BITS && !past_addr) begin
                cap_addr   <= full_addr[ADDR_W-1:0];
                cap_data   <= rx_byte;
                first_data <= 1'b1;
                if (op == eeprom_pkg::op_status_write || op == eeprom_pkg::op_mem_read) begin
                    done_kind <= op;
                end else begin
                    done_kind <= eeprom_pkg::op_none;
                end
            end else if (next_cnt == eeprom_pkg::ADDR_END_BITS) begin
                if (op == eeprom_pkg::op_mem_write) begin
                    done_kind  <= op;
                    cap_data   <= rx_byte;
                    first_data <= 1'b0;
                    if (!first_data) begin
                        cap_addr[3:0] <= cap_addr[3:0] + 4'h1;
                    end
                end
            end else if (op != eeprom_pkg::op_mem_read) begin
                done_kind <= eeprom_pkg::op_none; // A partial byte spoils the sequence.
            end
        end
    end

    // Busy changes in the system domain; the other status bits, save the latch cleared as the write cycle ends,
    // only move while the link is deselected, so they are read here as quasi-static levels.
    bit_sync2 #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_busy_sync (
        .clk (spi_clk),
        .rst (sys_rst),
        .d   (busy),
        .q   (busy_link)
    );

    assign status_link = {1'b1, psel, 1'b1, lock, bp, write_enable_latch_flag, busy_link};

    // Read pointer: the captured address for the first byte, then counting upward.
    always_comb begin
        next_ptr = cap_addr;
        if (so_drive) begin
            next_ptr = rd_ptr + ADDR_W'(1);
        end
    end

    // The arrays change only during a write cycle, when memory reads are refused.
    assign rd_byte = psel ? main_mem[next_ptr] : id_mem[next_ptr[3:0]];

    // Output shifter on the falling edge, loaded at each byte boundary.
    always_ff @(negedge spi_clk or posedge frame_rst) begin
        if (frame_rst) begin
            tx_sr    <= '0;
            so_out   <= 1'b0;
            so_drive <= 1'b0;
            rd_ptr   <= '0;
        end else if (hold_n) begin
            if (op == eeprom_pkg::op_status_read &&
                (bit_cnt == eeprom_pkg::OPCODE_BITS || bit_cnt == eeprom_pkg::ADDR_END_BITS)) begin
                so_drive <= 1'b1;
                so_out   <= status_link[7];
                tx_sr    <= {status_link[6:0], 1'b0};
            end else if (op == eeprom_pkg::op_mem_read && past_addr && !busy_link &&
                         bit_cnt == eeprom_pkg::ADDR_END_BITS) begin
                so_drive <= 1'b1;
                rd_ptr   <= next_ptr;
                so_out   <= rd_byte[7];
                tx_sr    <= {rd_byte[6:0], 1'b0};
            end else begin
                so_out <= tx_sr[7];
                tx_sr  <= {tx_sr[6:0], 1'b0};
            end
        end
    end

    // The pin floats when deselected, paused, or with nothing to send.
    assign so_oe_n = ~(so_drive & hold_n & ~cs_n);

    // Select, frame marker and write-inhibit into the system clock.
    bit_sync2 #(
        .W       (3),
        .RST_VAL (3'h4)
    ) u_sys_sync (
        .clk (clk_sys),
        .rst (sys_rst),
        .d   ({cs_n, frame_tgl, wp_n}),
        .q   ({cs_s, tgl_s, wp_s})
    );

    // A frame is acted on once, at the select rise, and only if the clock ran in it.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cs_prev  <= 1'b1;
            seen_tgl <= 1'b0;
        end else begin
            cs_prev <= cs_s;
            if (frame_end) begin
                seen_tgl <= tgl_s;
            end
        end
    end

    assign frame_end = cs_s & ~cs_prev & (tgl_s != seen_tgl);

    // Writes need the latch, the pin high, and an idle device.
    assign wr_ok      = write_enable_latch_flag & wp_s & ~busy;
    assign stat_wr_go = frame_end & wr_ok & (done_kind == eeprom_pkg::op_status_write);
    assign both_clear = ~cap_data[eeprom_pkg::ST_PSEL] & ~cap_data[eeprom_pkg::ST_LOCK];
    assign access_go  = frame_end & ~busy &
                        (done_kind == eeprom_pkg::op_mem_read ||
                         done_kind == eeprom_pkg::op_mem_write);

    // Identification writes also need the page unlocked and the array not fully protected.
    always_comb begin
        write_hit = 1'b0;
        if (!eeprom_pkg::in_protected(cap_addr[ADDR_W-1 -: 2], bp)) begin
            write_hit = psel | (lock & (bp != 2'h3));
        end
    end

    assign write_go = frame_end & wr_ok & write_hit &
                      (done_kind == eeprom_pkg::op_mem_write);

    // Write enable latch. Commands while busy are dropped, so a set cannot meet the clear.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            write_enable_latch_flag <= eeprom_pkg::LATCH_RESET;
        end else if (wc_done) begin
            write_enable_latch_flag <= 1'b0;
        end else if (frame_end && !busy) begin
            if (done_kind == eeprom_pkg::op_set_latch) begin
                write_enable_latch_flag <= 1'b1;
            end else if (done_kind == eeprom_pkg::op_clear_latch) begin
                write_enable_latch_flag <= 1'b0;
            end
        end
    end

    // Protect bits and lock: kept across the cycle, changed only by a status write.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bp   <= eeprom_pkg::BP_RESET;
            lock <= eeprom_pkg::LOCK_RESET;
        end else if (stat_wr_go) begin
            bp <= {cap_data[eeprom_pkg::ST_BP_HI], cap_data[eeprom_pkg::ST_BP_LO]};
            if (!both_clear) begin
                lock <= lock & cap_data[eeprom_pkg::ST_LOCK];
            end
        end
    end

    // Page select: written by a status write, restored to the array after any access.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            psel <= eeprom_pkg::PSEL_RESET;
        end else if (access_go) begin
            psel <= 1'b1;
        end else if (stat_wr_go && !both_clear) begin
            psel <= cap_data[eeprom_pkg::ST_PSEL];
        end
    end

    // Arrays hold data only and take no reset.
    always_ff @(posedge clk_sys) begin
        if (write_go) begin
            if (psel) begin
                main_mem[cap_addr] <= cap_data;
            end else begin
                id_mem[cap_addr[3:0]] <= cap_data;
            end
        end
    end

    // Every accepted write, to memory or status, runs the self-timed cycle.
    write_cycle_timer #(
        .CYCLES (WC_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .start   (write_go | stat_wr_go),
        .busy    (busy),
        .done    (wc_done)
    );

endmodule

`default_nettype wire

// *** core/write_cycle_timer.sv ***
// Purpose: Self-timed internal write cycle with a busy level and a done pulse.
// Assumes: Start is a one-cycle pulse that arrives only while idle.
// Notes:   The run length is trimmed by the latency of seeing the chip select rise.
`timescale 1ns/10ps
`default_nettype none

module write_cycle_timer #(
    parameter int CYCLES = eeprom_pkg::WC_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    localparam int                CW       = $clog2(CYCLES + 1);
    localparam logic [CW-1:0]     RUN_LAST = CW'(CYCLES - 1 - eeprom_pkg::EXEC_LATENCY);

    eeprom_pkg::timer_state_t state;
    logic [CW-1:0]            cnt;

    // The whole cycle fits inside the longest write time, counted from the select rise.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= eeprom_pkg::tmr_idle;
            cnt   <= '0;
        end else begin
            case (state)
                eeprom_pkg::tmr_idle: begin
                    cnt <= '0;
                    if (start) begin
                        state <= eeprom_pkg::tmr_run;
                    end
                end
                eeprom_pkg::tmr_run: begin
                    if (cnt == RUN_LAST) begin
                        state <= eeprom_pkg::tmr_done;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                eeprom_pkg::tmr_done: state <= eeprom_pkg::tmr_idle;
                default:              state <= eeprom_pkg::tmr_idle;
            endcase
        end
    end

    // Busy covers the done cycle too, so the latch clear and busy fall line up.
    assign busy = state != eeprom_pkg::tmr_idle;
    assign done = state == eeprom_pkg::tmr_done;

endmodule

`default_nettype wire

// *** verification/spi_eeprom_command_status_properties.sv ***
// Purpose: Port assertions for the serial command and status block.
// Assumes: The host keeps the serial clock low while paused.
// Notes:   Helpers rebuild the opcode from the serial input.
`timescale 1ns/10ps
`default_nettype none

module spi_eeprom_command_status_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_out,
    input wire logic so_oe_n
);
    logic [4:0] n_rise;
    logic [7:0] op;
    logic       rd_op;
    logic       known;

    // Select high clears the count, as in the block, so no frame leaks into the next.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            n_rise <= 5'h00;
            op     <= 8'h00;
        end else if (hold_n && n_rise != 5'h1f) begin
            n_rise <= n_rise + 5'h01;
            if (n_rise < 5'h08) op <= {op[6:0], si};
        end
    end

    // Bit 3 of the memory codes carries an address bit, so it is masked there.
    assign rd_op = op == eeprom_pkg::status_read_cmd
                || (op & 8'hf7) == eeprom_pkg::memory_read_cmd;
    assign known = rd_op || op == eeprom_pkg::set_write_latch_cmd
                || op == eeprom_pkg::clear_write_latch_cmd
                || op == eeprom_pkg::status_write_cmd
                || (op & 8'hf7) == eeprom_pkg::memory_write_cmd;

    sequence op_seen;
        n_rise >= 5'h08;
    endsequence
    sequence status_due;
        n_rise == 5'h08 && op == eeprom_pkg::status_read_cmd && hold_n;
    endsequence

    chk_idle_float: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cs_n |-> so_oe_n) else $error("output driven while deselected");
    chk_pause_float: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !hold_n |-> so_oe_n) else $error("output driven while paused");
    chk_pause_freeze: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !hold_n && !cs_n && !$past(hold_n) && !$past(cs_n) |-> $stable(so_out))
        else $error("output moved while paused");
    chk_opcode_quiet: assert property (@(posedge spi_clk) disable iff (sys_rst || cs_n)
        n_rise < 5'h08 |-> so_oe_n) else $error("output driven during opcode");
    chk_unknown_quiet: assert property (@(posedge spi_clk) disable iff (sys_rst || cs_n)
        op_seen ##0 !known |-> so_oe_n) else $error("unknown code answered");
    chk_write_quiet: assert property (@(posedge spi_clk) disable iff (sys_rst || cs_n)
        op_seen ##0 (known && !rd_op) |-> so_oe_n) else $error("write code answered");
    chk_status_answer: assert property (@(posedge spi_clk) disable iff (sys_rst || cs_n)
        status_due |-> !so_oe_n) else $error("status byte not driven");
    chk_read_wait: assert property (@(posedge spi_clk) disable iff (sys_rst || cs_n)
        n_rise < 5'h10 && (op & 8'hf7) == eeprom_pkg::memory_read_cmd |-> so_oe_n)
        else $error("read data before address");
endmodule

`default_nettype wire

// *** verification/spi_eeprom_command_status_test.sv ***
// Purpose: Self-checking bench for the serial command and status block.
// Assumes: The write cycle is cut to 200 system clocks to keep the run short.
// Notes:   Memory content is judged only where this bench wrote it.
`timescale 1ns/10ps
`default_nettype none

module spi_eeprom_command_status_test;
    localparam int WC = 200;
    logic       clk_sys;
    logic       sys_rst;
    logic       wp_n;
    wire logic  spi_clk;
    wire logic  cs_n;
    wire logic  si;
    wire logic  hold_n;
    wire logic  so_out;
    wire logic  so_oe_n;
    wire logic  so;
    logic [7:0] st;
    logic [7:0] rd;
    logic [8:0] lo [1:3];
    int         n_mismatch;
    int         samples_checked;

    // The pin floats unless the block enables its driver.
    assign so = so_oe_n ? 1'bz : so_out;

    spi_eeprom_command_status #(.ADDR_W(9), .WC_CYCLES(WC)) u_spi_eeprom_command_status (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));
    spi_host_model u_host (.so(so), .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .hold_n(hold_n));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Frame helpers; each write sets the latch first.
    task automatic cmd1(input logic [7:0] op);
        u_host.sel();
        u_host.byte_x(op, rd);
        u_host.desel();
    endtask
    task automatic rd_status(input logic [7:0] op = eeprom_pkg::status_read_cmd);
        u_host.sel();
        u_host.byte_x(op, rd);
        u_host.byte_x(8'h00, st);
        u_host.desel();
    endtask
    task automatic wr_status(input logic [7:0] d);
        cmd1(eeprom_pkg::set_write_latch_cmd);
        u_host.sel();
        u_host.byte_x(eeprom_pkg::status_write_cmd, rd);
        u_host.byte_x(d, rd);
        u_host.desel();
    endtask
    task automatic mem(input logic wr, input logic [8:0] a, input logic [7:0] d);
        if (wr) cmd1(eeprom_pkg::set_write_latch_cmd);
        u_host.sel();
        u_host.byte_x((wr ? eeprom_pkg::memory_write_cmd : eeprom_pkg::memory_read_cmd)
                      | {4'h0, a[8], 3'h0}, rd);
        u_host.byte_x(a[7:0], rd);
        u_host.byte_x(d, rd);
        u_host.desel();
    endtask
    // Polls are bounded, so a stuck busy bit ends the run.
    task automatic poll();
        for (int i = 0; i < 20; i++) begin
            rd_status();
            if (st[0] === 1'b0) return;
        end
        $display("unexpected busy wait: expected 0, seen 1");
        n_mismatch++;
        close_out();
    endtask

    task automatic t_basic();
        rd_status();
        check("status after reset", 8'hf0, st);
        u_host.sel();
        u_host.byte_x(eeprom_pkg::status_read_cmd, rd);
        u_host.hold_on();
        check("paused enable", 8'h01, {7'h00, so_oe_n});
        u_host.hold_off();
        u_host.byte_x(8'h00, st);
        u_host.desel();
        check("status after pause", 8'hf0, st);
        u_host.mode3 = 1'b1;
        rd_status();
        check("mode 3 status", 8'hf0, st);
        u_host.mode3 = 1'b0;
        cmd1(eeprom_pkg::set_write_latch_cmd);
        rd_status();
        check("latch set", 8'hf2, st);
        rd_status(8'hff);
        rd_status();
        check("unknown code", 8'hf2, st);
        cmd1(eeprom_pkg::clear_write_latch_cmd);
        rd_status();
        check("latch clear", 8'hf0, st);
    endtask

    task automatic t_status();
        wr_status(8'h8e);
        rd_status();
        check("status busy", 8'hff, st);
        wr_status(8'h50);
        poll();
        check("status written", 8'hfc, st);
        @(posedge clk_sys) wp_n <= 1'b0;
        wr_status(8'h50);
        rd_status();
        check("write inhibit", 8'hfe, st);
        @(posedge clk_sys) wp_n <= 1'b1;
        wr_status(8'h50);
        poll();
        check("write allowed", 8'hf0, st);
    endtask

    task automatic t_protect();
        for (int b = 1; b < 4; b++) begin
            wr_status(8'h50 | 8'(b << 2));
            poll();
            mem(1'b1, lo[b], 8'h3c);
            rd_status();
            check("protected write", {4'hf, 2'(b), 2'h2}, st);
            if (b < 3) begin
                mem(1'b1, lo[b] - 9'h001, 8'hc0 | 8'(b));
                poll();
                mem(1'b0, lo[b] - 9'h001, 8'h00);
                check("read back", 8'hc0 | 8'(b), rd);
            end
        end
        wr_status(8'h50);
        poll();
    endtask

    task automatic t_idpage();
        wr_status(8'h10);
        poll();
        check("page select", 8'hb0, st);
        mem(1'b1, 9'h003, 8'h5a);
        rd_status();
        check("select returns", 8'hf3, st);
        poll();
        wr_status(8'h10);
        poll();
        mem(1'b0, 9'h003, 8'h00);
        check("page read", 8'h5a, rd);
        wr_status(8'h40);
        poll();
        check("page locked", 8'he0, st);
        wr_status(8'h10);
        poll();
        check("select with lock", 8'ha0, st);
        mem(1'b1, 9'h004, 8'h77);
        rd_status();
        check("locked write", 8'he2, st);
    endtask

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Reset for four cycles, then a settling wait before the first frame.
    initial begin
        sys_rst         = 1'b1;
        wp_n            = 1'b1;
        n_mismatch      = 0;
        samples_checked = 0;
        lo[1]           = 9'h180;
        lo[2]           = 9'h100;
        lo[3]           = 9'h000;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (8750) @(posedge clk_sys);
        t_basic();
        t_status();
        t_protect();
        t_idpage();
        close_out();
    end
endmodule

bind spi_eeprom_command_status spi_eeprom_command_status_properties u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));

`default_nettype wire

// *** verification/spi_host_model.sv ***
// Purpose: Behavioural SPI host that frames commands for the block.
// Assumes: The serial clock runs at 80 ns only inside a frame.
// Notes:   Released data shows the inverse so no stale bit lingers.
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
    input  wire logic so,
    output logic      spi_clk,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n
);
    logic mode3;

    // Idle levels before the first frame.
    initial begin
        mode3   = 1'b0;
        spi_clk = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
        hold_n  = 1'b1;
    end

    // The idle clock level picks the mode; the odd offset keeps the phase unrelated.
    task automatic sel();
        #13 spi_clk = mode3;
        #20 cs_n = 1'b0;
        #40;
    endtask

    // Data changes with the clock low and is read back at the rising edge.
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_clk = 1'b0;
            si      = tx[i];
            #40 spi_clk = 1'b1;
            rx[i] = so;
            #40;
        end
    endtask

    // Pause and resume only while the clock is low.
    task automatic hold_on();
        spi_clk = 1'b0;
        #20 hold_n = 1'b0;
        #100;
    endtask
    task automatic hold_off();
        hold_n = 1'b1;
        #20;
    endtask

    // Mode 3 leaves the clock high between frames.
    task automatic desel();
        if (!mode3) spi_clk = 1'b0;
        #20 cs_n = 1'b1;
        si = ~si;
        #200;
    endtask
endmodule

`default_nettype wire
